// File: shared/crc_pkg.sv
// Package for the comparator reference control block: offsets, fields, types
package crc_pkg;
  localparam int unsigned ADDR_W = 4;
  // Register byte addresses
  localparam logic [3:0] REF_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] REF_STATUS_OFFSET = 4'h4;
  // Field positions in ref_control
  localparam int unsigned ENABLE_BIT = 15;
  localparam int unsigned PIN_OE_BIT = 6;
  localparam int unsigned RANGE_BIT = 5;
  localparam int unsigned SOURCE_BIT = 4;
  localparam int unsigned TAP_LSB = 0;
  localparam int unsigned TAP_W = 4;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_807f;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // Ladder scale: low range taps/24, high range 8/32 + taps/32
  localparam int unsigned LOW_DEN = 24;
  localparam int unsigned HIGH_DEN = 32;
  localparam logic [5:0] HIGH_BASE = 6'h08;

  typedef struct packed {
    logic enable;
    logic pin_oe;
    logic range_low;
    logic source_ext;
    logic [TAP_W-1:0] tap;
  } crc_ctrl_t;
endpackage : crc_pkg

// File: rtl/crc_ref_control.sv
// Comparator reference control register with Avalon-MM slave
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module crc_ref_control
  import crc_pkg::*;
#(
  // Ladder geometry
  parameter int unsigned TAP_COUNT = 16,
  // Level resolution: a common multiple of both step sizes
  parameter int unsigned LEVEL_STEPS = 96
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // To the analogue ladder
  output logic ladder_power_on,
  output logic ref_pin_output_enable,
  output logic ref_range_select,
  output logic ref_source_select,
  output logic [TAP_W-1:0] ref_tap_index,
  // Ladder level to comparators, in 1/96 of ladder_supply_span
  output logic [6:0] comparator_reference_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on avs_address:
  //   0x0 ref_control  bit 15 enable, 6 pin connect, 5 low range,
  //                    4 external supply, 3:0 tap index; rest reads zero
  //   0x4 status       read-only level in bits 6:0, writes ignored
  //   others           read zero, writes ignored
  // Each access costs two cycles: one wait state, then the answer.
  // Software must leave one idle cycle after clearing enable; the logic
  // does not guard against an access there.

  ////////////////////////////////////////////////////////////////////////////
  // Derived step sizes and worst-case levels
  localparam int unsigned LOW_STEP = LEVEL_STEPS / LOW_DEN;
  localparam int unsigned HIGH_STEP = LEVEL_STEPS / HIGH_DEN;
  localparam int unsigned LOW_MAX = (TAP_COUNT - 1) * LOW_STEP;
  localparam int unsigned HIGH_MAX = (TAP_COUNT - 1 + int'(HIGH_BASE)) * HIGH_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // Mask of every implemented bit, built from the field positions
  function automatic logic [31:0] implemented_mask();
    logic [31:0] mask;
    mask = 32'h0000_0000;
    mask[ENABLE_BIT] = 1'b1;
    mask[PIN_OE_BIT] = 1'b1;
    mask[RANGE_BIT] = 1'b1;
    mask[SOURCE_BIT] = 1'b1;
    for (int i = 0; i < TAP_W; i++) begin
      mask[TAP_LSB + i] = 1'b1;
    end
    return mask;
  endfunction : implemented_mask

  // Byte lanes not enabled keep their old contents
  function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0] lanes);
    logic [31:0] merged;
    merged = old_word;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        merged[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return merged;
  endfunction : lane_merge

  // Low range: tap steps from zero
  function automatic logic [6:0] low_level(input logic [6:0] t);
    return 7'(t * 7'(LOW_STEP));
  endfunction : low_level

  // High range: starts a quarter of the span up
  function automatic logic [6:0] high_level(input logic [6:0] t);
    return 7'((7'(HIGH_BASE) + t) * 7'(HIGH_STEP));
  endfunction : high_level

  // Level in steps of the span; zero-extended tap keeps the product in range
  function automatic logic [6:0] level_of(input logic low,
                                          input logic [TAP_W-1:0] tap);
    logic [6:0] t;
    t = 7'(tap);
    if (low) begin
      level_of = low_level(t);
    end else begin
      level_of = high_level(t);
    end
  endfunction : level_of

  // Field decode from the register image
  function automatic crc_ctrl_t ctrl_of(input logic [31:0] word);
    crc_ctrl_t c;
    c.enable = word[ENABLE_BIT];
    c.pin_oe = word[PIN_OE_BIT];
    c.range_low = word[RANGE_BIT];
    c.source_ext = word[SOURCE_BIT];
    c.tap = word[TAP_LSB +: TAP_W];
    return c;
  endfunction : ctrl_of

  // Read multiplexer; unmapped addresses give zero
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                            input logic [31:0] control,
                                            input logic [6:0] level);
    logic [31:0] word;
    unique case (addr)
      REF_CONTROL_OFFSET: word = control & CONTROL_MASK;
      REF_STATUS_OFFSET: word = {25'h0, level};
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: refuse inconsistent settings and those the fixed ports cannot carry
  if (TAP_COUNT != (1 << TAP_W)) begin : g_bad_tap_count
    $error("Tap count must fill the tap field exactly");
  end
  if (LEVEL_STEPS == 0) begin : g_no_steps
    $error("Level resolution must not be zero");
  end
  if ((LEVEL_STEPS % LOW_DEN) != 0 || (LEVEL_STEPS % HIGH_DEN) != 0) begin : g_bad_steps
    $error("Level resolution must divide into both step sizes");
  end
  if (LOW_MAX > 127 || HIGH_MAX > 127) begin : g_bad_level_width
    $error("Highest level does not fit the level output");
  end
  if (4 * int'(HIGH_BASE) != HIGH_DEN) begin : g_bad_base
    $error("High range base must be a quarter of the span");
  end
  if (implemented_mask() != CONTROL_MASK) begin : g_bad_mask
    $error("Field positions disagree with the implemented-bit mask");
  end
  if (ENABLE_BIT > 31 || TAP_LSB + TAP_W > 32) begin : g_bad_fields
    $error("Field positions fall outside the register");
  end
  if (ADDR_W < 3) begin : g_bad_addr
    $error("Address too narrow for the status register");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ref_control_reg;
  logic [31:0] ref_control_next;
  logic read_start;
  logic write_commit;
  crc_ctrl_t ctrl;
  logic ladder_power_next;
  logic pin_enable_next;
  logic range_next;
  logic source_next;
  logic [TAP_W-1:0] tap_next;
  logic [6:0] level_next;

  ////////////////////////////////////////////////////////////////////////////
  // One wait cycle: waitrequest drops on the edge after the request is seen
  // and rises again on the next, so a held request is served at most every second cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Read data is fetched while waitrequest is still high
  always_comb begin
    read_start = avs_read & avs_waitrequest;
  end

  // Write takes effect at the edge where waitrequest is seen low
  always_comb begin
    write_commit = avs_write & ~avs_waitrequest & (avs_address == REF_CONTROL_OFFSET);
  end

  // Byte lanes merged, unimplemented bits masked off
  always_comb begin
    ref_control_next = lane_merge(ref_control_reg, avs_writedata, avs_byteenable)
                       & CONTROL_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_control_reg <= CONTROL_RESET;
    end else if (write_commit) begin
      // Lanes not enabled keep their fields, so enable writes alone touch nothing else
      ref_control_reg <= ref_control_next;
    end
  end

  // Read data registered one edge early so it stands when waitrequest is low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (read_start) begin
      avs_readdata <= read_word(avs_address, ref_control_reg, comparator_reference_level);
    end
  end

  always_comb begin
    ctrl = ctrl_of(ref_control_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next ladder settings from the current register image
  always_comb begin
    ladder_power_next = ctrl.enable;
    // Pin only connected while the ladder runs; a dead ladder has no level
    pin_enable_next = ctrl.pin_oe & ctrl.enable;
    range_next = ctrl.range_low;
    source_next = ctrl.source_ext;
    tap_next = ctrl.tap;
    // Comparators see the level whether or not the pin is connected
    level_next = ctrl.enable ? level_of(ctrl.range_low, ctrl.tap) : 7'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ladder outputs, one edge behind the register and static between writes

  // Power-down removes ladder current while the enable bit is clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ladder_power_on <= 1'b0;
    end else begin
      ladder_power_on <= ladder_power_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_pin_output_enable <= 1'b0;
    end else begin
      ref_pin_output_enable <= pin_enable_next;
    end
  end

  // 1 picks the low range
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_range_select <= 1'b0;
    end else begin
      ref_range_select <= range_next;
    end
  end

  // 1 feeds the ladder from the external reference pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_source_select <= 1'b0;
    end else begin
      ref_source_select <= source_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_tap_index <= 4'h0;
    end else begin
      ref_tap_index <= tap_next;
    end
  end

  // Zero while disabled, so comparators never see a stale level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      comparator_reference_level <= 7'h00;
    end else begin
      comparator_reference_level <= level_next;
    end
  end

endmodule : crc_ref_control
`default_nettype wire

// File: dv/crc_ladder_model.sv
// Behavioural ladder as seen by the comparators and the output pin
`timescale 1ns/1ps
`default_nettype none
module crc_ladder_model (
  // Settings from the block
  input wire logic on,
  input wire logic oe,
  input wire logic low,
  input wire logic ext,
  input wire logic [3:0] tap,
  // Levels in 1/96 of the span
  output var int lvl96,
  output var int pin96,
  // Supply choice seen by the ladder
  output logic span_ext
);
  assign lvl96 = !on ? 0 : low ? tap * 4 : (8 + tap) * 3;
  // Pin shows -1 when cut off; comparators keep the level
  assign pin96 = oe ? lvl96 : -1;
  assign span_ext = ext;
endmodule : crc_ladder_model
`default_nettype wire

// File: dv/crc_ref_control_assertions.sv
// Port checker for the reference control block
`timescale 1ns/1ps
`default_nettype none
module crc_ref_control_assertions import crc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic [3:0] avs_byteenable,
  // Ladder
  input wire logic [3:0] ref_tap_index,
  input wire logic ladder_power_on,
  input wire logic ref_pin_output_enable,
  input wire logic ref_range_select,
  input wire logic ref_source_select,
  input wire logic [6:0] comparator_reference_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Full-word control write accepted at this edge
  wire logic w = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable == 4'hf;
  power_on_a: assert property (w |-> ##2 ladder_power_on == $past(avs_writedata[15], 2))
    else $error("power bit wrong");
  pin_oe_a: assert property (w |-> ##2 ref_pin_output_enable ==
    ($past(avs_writedata[6], 2) & $past(avs_writedata[15], 2))) else $error("pin enable wrong");
  range_sel_a: assert property (w |-> ##2 ref_range_select == $past(avs_writedata[5], 2))
    else $error("range wrong");
  source_sel_a: assert property (w |-> ##2 ref_source_select == $past(avs_writedata[4], 2))
    else $error("source wrong");
  tap_sel_a: assert property (w |-> ##2 ref_tap_index == $past(avs_writedata[3:0], 2))
    else $error("tap wrong");
  level_calc_a: assert property (comparator_reference_level == (!ladder_power_on ? 7'h0 :
    ref_range_select ? 7'(ref_tap_index * 4) : 7'(3 * (8 + ref_tap_index)))) else $error("level");
  read_zero_a: assert property (avs_read && !avs_waitrequest |->
    (avs_readdata & ~CONTROL_MASK) == 32'h0) else $error("reserved bits read");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("wait state count");
endmodule : crc_ref_control_assertions
bind crc_ref_control crc_ref_control_assertions i_chk (.sys_clk, .reset, .avs_read, .avs_write,
  .avs_waitrequest, .avs_address, .avs_writedata, .avs_readdata, .avs_byteenable, .ref_tap_index,
  .ladder_power_on, .ref_pin_output_enable, .ref_range_select, .ref_source_select,
  .comparator_reference_level);
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the reference control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
  import crc_pkg::*;
  logic sys_clk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest, on, oe, low, ext, sx;
  logic [3:0] avs_address = 0, avs_byteenable = 0, tap;
  logic [31:0] avs_writedata = 0, avs_readdata, rv, m = 0;
  logic [6:0] lvl;
  int fail_count = 0, n_tests = 0, cyc = 0, seed = 4, l96, p96;
  // Writes 4-5 touch only the enable lane
  logic [31:0] tbl[6] = '{32'hffff_ffff, 32'h802f, 32'h8000, 32'h805a, 32'h0, 32'h8000};
  crc_ref_control i_crc_ref_control (.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ladder_power_on(on),
    .ref_pin_output_enable(oe), .ref_range_select(low), .ref_source_select(ext),
    .ref_tap_index(tap), .comparator_reference_level(lvl));
  crc_ladder_model i_crc_ladder_model (.on, .oe, .low, .ext, .tap, .lvl96(l96), .pin96(p96),
    .span_ext(sx));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic bus(input logic wr, input logic [3:0] a, be, input logic [31:0] d);
    @(posedge sys_clk);
    {avs_address, avs_byteenable, avs_writedata} <= {a, be, d};
    {avs_write, avs_read} <= {wr, !wr};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    // Lane-wise model update; only the control offset is writable
    if (wr && a == 4'h0) for (int i = 0; i < 4; i++) if (be[i]) m[i*8+:8] = d[i*8+:8];
    m = m & CONTROL_MASK;
    {avs_write, avs_read} <= 2'b00;
  endtask : bus
  task automatic cmp();
    int e;
    e = !m[15] ? 0 : m[5] ? m[3:0] * 4 : (8 + m[3:0]) * 3;
    repeat (2) @(posedge sys_clk);
    bus(0, 4'h0, 4'hf, 0);
    `CHK("ctrl", m, rv)
    `CHK("on", m[15], on)
    `CHK("pin", m[6] & m[15], oe)
    `CHK("range", m[5], low)
    `CHK("src", m[4], ext)
    `CHK("tap", m[3:0], tap)
    `CHK("lvl", 7'(e), lvl)
    `CHK("cmp", e, l96)
    `CHK("pinlvl", (m[6] & m[15]) ? e : -1, p96)
    `CHK("span", m[4], sx)
    bus(0, 4'h4, 4'hf, 0);
    `CHK("status", 32'(e), rv)
  endtask : cmp
  task end_of_test();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) if (++cyc > 4000) begin
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    cmp();
    foreach (tbl[j]) begin
      bus(1, 4'h0, j < 4 ? 4'hf : 4'h2, tbl[j]);
      cmp();
    end
    $display("fixed writes done");
    // Random lanes and addresses, unmapped ones must be ignored
    for (int k = 0; k < 24; k++) begin
      bus(1, 4'(($random(seed) & 3) << 2), 4'($random(seed)), $random(seed));
      cmp();
    end
    $display("random writes done");
    bus(0, 4'h8, 4'hf, 0);
    `CHK("unmapped", 32'h0, rv)
    end_of_test();
  end
endmodule : tb
`default_nettype wire
